// File: core/ccr_debounce.sv
`default_nettype none

// Qualifies a level once it has stayed high for delay cycles
module ccr_debounce (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // Level and delay
  input  wire logic       level,
  input  wire logic [8:0] delay,
  // Qualified level
  output logic            qual
);

  logic [8:0] cnt_reg;
  logic [8:0] cnt_next;
  logic       qual_reg;
  logic       qual_next;

  // Drop at once, rise only after a full quiet-free run
  always_comb begin
    cnt_next  = cnt_reg;
    qual_next = qual_reg;
    if (!resetn || !level) begin
      cnt_next  = 9'h000;
      qual_next = 1'b0;
    end else if (cnt_reg >= delay) begin
      qual_next = 1'b1;
    end else begin
      cnt_next = cnt_reg + 9'h001;
    end
  end

  always_ff @(posedge clk) begin
    cnt_reg  <= cnt_next;
    qual_reg <= qual_next;
  end

  assign qual = qual_reg;

endmodule

`default_nettype wire

// File: core/ccr_defs.svh
`ifndef CCR_DEFS_SVH
`define CCR_DEFS_SVH

// Command codes of the words held here
`define CCR_CMD_PRIMARY    8'h39
`define CCR_CMD_SECONDARY  8'h3C
`define CCR_CMD_TERTIARY   8'h3D
`define CCR_CMD_AC_THR     8'h47
`define CCR_CMD_DC_THR     8'h48

// Reset values
`define CCR_PRIMARY_RST    8'h00
`define CCR_SECONDARY_RST  16'h0000
`define CCR_TERTIARY_RST   16'h0000
`define CCR_AC_THR_RST     16'h0C00
`define CCR_DC_THR_RST     16'h1000

// Writable bits of the threshold words
`define CCR_AC_THR_MASK    16'h1F80
`define CCR_DC_THR_MASK    16'h3F00

// Field positions
`define CCR_WD_DIS_BIT     7
`define CCR_HSF_LSB        5
`define CCR_LPT_LSB        3
`define CCR_DEB_LSB        9
`define CCR_HOLD_LSB       6

// Short-detect thresholds in mV, per code
`define CCR_HSF_0_MV       10'h190
`define CCR_HSF_1_MV       10'h1F4
`define CCR_HSF_2_MV       10'h258
`define CCR_HSF_3_MV       10'h320

// Low-power discharge thresholds in mA, per code
`define CCR_LPT_0_MA       16'h2EE0
`define CCR_LPT_1_MA       16'h2710
`define CCR_LPT_2_MA       16'h1F40
`define CCR_LPT_3_MA       16'h1770

// Timing
`define CCR_CLK_HZ         10000000
`define CCR_WD_TIMEOUT_S   175
`define CCR_LSV_DEB_US     10
`define CCR_DEB_0_US       1
`define CCR_DEB_1_US       5
`define CCR_DEB_2_US       10
`define CCR_DEB_3_US       40
`define CCR_HOLD_STEP_US   1000
// Whole-MHz clock only; keeps long times clear of 32-bit overflow
`define CCR_US_TO_CYC(t)   ((t) * (`CCR_CLK_HZ / 1000000))

`endif

// File: core/ccr_pkg.sv
`default_nettype none

package ccr_pkg;

  // Alert state, one-hot
  typedef enum logic [1:0] {
    CCR_IDLE = 2'b01,
    CCR_HOLD = 2'b10
  } ccr_state_t;

  // Decoded write-word transfer
  typedef struct packed {
    logic        valid;
    logic [7:0]  cmd;
    logic [15:0] data;
  } ccr_wr_t;

  // Live conditions from the power stage
  typedef struct packed {
    logic        adapter_present;
    logic        power_monitor_en;
    logic        low_power_mode;
    logic        low_sys_voltage;
    logic [15:0] adapter_ma;
    logic [15:0] battery_ma;
  } ccr_sense_t;

  // Settings handed to the power stage
  typedef struct packed {
    logic [9:0]  hs_short_mv;
    logic [15:0] ac_thr_ma;
    logic [15:0] dc_thr_ma;
    logic [15:0] secondary_word;
  } ccr_cfg_t;

endpackage

`default_nettype wire

// File: core/ccr_regs.sv
`default_nettype none
`include "ccr_defs.svh"

// Behaviour
// - Tertiary bits 10:9 pick debounce for adapter and battery overcurrent.
// - Low system voltage alert uses a fixed 10 us debounce.
// - Tertiary bits 8:6 pick the minimum alert hold time.
// - Overcurrent asserts alert after debounce, held at least the hold time.
// - Adapter present, watchdog on: 175 s without ceiling write stops charge.
// - A ceiling write after timeout enables charging again.
// - Primary bit 7: 0 enables watchdog (default), 1 disables it.
// - Primary bits 6:5 pick short threshold 400/500/600/800 mV.
// - Primary bits 4:3 set discharge threshold only in low-power mode with power monitor off.
module ccr_regs #(
  parameter logic [7:0]  VOLT_CEIL_CMD  = 8'h10,
  parameter logic [7:0]  CURR_CEIL_CMD  = 8'h11,
  parameter logic [30:0] WD_TIMEOUT_CYC =
    31'(`CCR_WD_TIMEOUT_S * `CCR_CLK_HZ),
  parameter logic [16:0] HOLD_STEP_CYC  =
    17'(`CCR_US_TO_CYC(`CCR_HOLD_STEP_US))
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                resetn,
  // Write-word transfers and read-back
  input  wire ccr_pkg::ccr_wr_t    wr,
  input  wire logic [7:0]          rd_cmd,
  output logic [15:0]              rd_data,
  // Power stage
  input  wire ccr_pkg::ccr_sense_t sense,
  output ccr_pkg::ccr_cfg_t        cfg,
  output logic                     charge_en,
  output logic                     wd_expired,
  // Open-drain throttle alert, active low
  input  wire logic                alert_n_in,
  output logic                     alert_n_out,
  output logic                     alert_oe
);

  localparam logic [8:0] LSV_DEB = 9'(`CCR_US_TO_CYC(`CCR_LSV_DEB_US));
  localparam logic [8:0] DEB_0   = 9'(`CCR_US_TO_CYC(`CCR_DEB_0_US));
  localparam logic [8:0] DEB_1   = 9'(`CCR_US_TO_CYC(`CCR_DEB_1_US));
  localparam logic [8:0] DEB_2   = 9'(`CCR_US_TO_CYC(`CCR_DEB_2_US));
  localparam logic [8:0] DEB_3   = 9'(`CCR_US_TO_CYC(`CCR_DEB_3_US));

  logic [7:0]          primary_reg,   primary_next;
  logic [15:0]         secondary_reg, secondary_next;
  logic [15:0]         tertiary_reg,  tertiary_next;
  logic [15:0]         ac_thr_reg,    ac_thr_next;
  logic [15:0]         dc_thr_reg,    dc_thr_next;
  logic [15:0]         rd_data_reg,   rd_data_next;
  ccr_pkg::ccr_cfg_t   cfg_reg,       cfg_next;
  logic [30:0]         wd_cnt_reg,    wd_cnt_next;
  logic                expired_reg,   expired_next;
  logic                charge_reg,    charge_next;
  ccr_pkg::ccr_state_t state_reg,     state_next;
  logic [16:0]         hold_cnt_reg,  hold_cnt_next;
  logic                alert_reg,     alert_next;
  logic                ceiling_wr;
  logic                wd_armed;
  logic [8:0]          oc_delay;
  logic [16:0]         hold_target;
  logic [15:0]         dc_thr_sel;
  logic                ac_over;
  logic                dc_over;
  logic                ac_qual;
  logic                dc_qual;
  logic                lsv_qual;
  logic                any_cause;

  ////////////////////////////////////////////////////////////////////////////
  // Register file

  // Command decode; unknown commands are ignored
  always_comb begin
    primary_next   = primary_reg;
    secondary_next = secondary_reg;
    tertiary_next  = tertiary_reg;
    ac_thr_next    = ac_thr_reg;
    dc_thr_next    = dc_thr_reg;
    if (!resetn) begin
      primary_next   = `CCR_PRIMARY_RST;
      secondary_next = `CCR_SECONDARY_RST;
      tertiary_next  = `CCR_TERTIARY_RST;
      ac_thr_next    = `CCR_AC_THR_RST;
      dc_thr_next    = `CCR_DC_THR_RST;
    end else if (wr.valid) begin
      if (wr.cmd == `CCR_CMD_PRIMARY) begin
        primary_next = wr.data[7:0];
      end else if (wr.cmd == `CCR_CMD_SECONDARY) begin
        secondary_next = wr.data;
      end else if (wr.cmd == `CCR_CMD_TERTIARY) begin
        tertiary_next = wr.data;
      end else if (wr.cmd == `CCR_CMD_AC_THR) begin
        ac_thr_next = wr.data & `CCR_AC_THR_MASK;
      end else if (wr.cmd == `CCR_CMD_DC_THR) begin
        dc_thr_next = wr.data & `CCR_DC_THR_MASK;
      end
    end
  end

  // Read-back answers one cycle after the command; unmapped reads zero
  always_comb begin
    rd_data_next = 16'h0000;
    if (!resetn) begin
      rd_data_next = 16'h0000;
    end else if (rd_cmd == `CCR_CMD_PRIMARY) begin
      rd_data_next = {8'h00, primary_reg};
    end else if (rd_cmd == `CCR_CMD_SECONDARY) begin
      rd_data_next = secondary_reg;
    end else if (rd_cmd == `CCR_CMD_TERTIARY) begin
      rd_data_next = tertiary_reg;
    end else if (rd_cmd == `CCR_CMD_AC_THR) begin
      rd_data_next = ac_thr_reg;
    end else if (rd_cmd == `CCR_CMD_DC_THR) begin
      rd_data_next = dc_thr_reg;
    end
  end

  always_ff @(posedge clk) begin
    primary_reg   <= primary_next;
    secondary_reg <= secondary_next;
    tertiary_reg  <= tertiary_next;
    ac_thr_reg    <= ac_thr_next;
    dc_thr_reg    <= dc_thr_next;
    rd_data_reg   <= rd_data_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Settings for the power stage

  // Discharge threshold source; the 0x48 word also covers adapter mode
  always_comb begin
    dc_thr_sel = dc_thr_reg;
    if (sense.power_monitor_en) begin
      dc_thr_sel = dc_thr_reg;
    end else if (sense.low_power_mode) begin
      case (primary_reg[`CCR_LPT_LSB +: 2])
        2'b00:   dc_thr_sel = `CCR_LPT_0_MA;
        2'b01:   dc_thr_sel = `CCR_LPT_1_MA;
        2'b10:   dc_thr_sel = `CCR_LPT_2_MA;
        default: dc_thr_sel = `CCR_LPT_3_MA;
      endcase
    end
  end

  // Registered so the outputs never glitch on a decode change
  always_comb begin
    cfg_next                = cfg_reg;
    cfg_next.ac_thr_ma      = ac_thr_reg;
    cfg_next.dc_thr_ma      = dc_thr_sel;
    cfg_next.secondary_word = secondary_reg;
    case (primary_reg[`CCR_HSF_LSB +: 2])
      2'b00:   cfg_next.hs_short_mv = `CCR_HSF_0_MV;
      2'b01:   cfg_next.hs_short_mv = `CCR_HSF_1_MV;
      2'b10:   cfg_next.hs_short_mv = `CCR_HSF_2_MV;
      default: cfg_next.hs_short_mv = `CCR_HSF_3_MV;
    endcase
    if (!resetn) begin
      cfg_next.hs_short_mv    = `CCR_HSF_0_MV;
      cfg_next.ac_thr_ma      = `CCR_AC_THR_RST;
      cfg_next.dc_thr_ma      = `CCR_DC_THR_RST;
      cfg_next.secondary_word = `CCR_SECONDARY_RST;
    end
  end

  always_ff @(posedge clk) begin
    cfg_reg <= cfg_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host-activity watchdog

  assign ceiling_wr = wr.valid &&
                      (wr.cmd == VOLT_CEIL_CMD || wr.cmd == CURR_CEIL_CMD);
  assign wd_armed   = sense.adapter_present &&
                      !primary_reg[`CCR_WD_DIS_BIT];

  // A ceiling write restarts the count, so it cannot race a timeout
  always_comb begin
    wd_cnt_next  = wd_cnt_reg;
    expired_next = expired_reg;
    if (!resetn) begin
      wd_cnt_next  = 31'h00000000;
      expired_next = 1'b0;
    end else if (ceiling_wr) begin
      wd_cnt_next  = 31'h00000000;
      expired_next = 1'b0;
    end else if (!wd_armed) begin
      wd_cnt_next = 31'h00000000;
    end else if (!expired_reg) begin
      if (wd_cnt_reg == WD_TIMEOUT_CYC - 31'h00000001) begin
        wd_cnt_next  = 31'h00000000;
        expired_next = 1'b1;
      end else begin
        wd_cnt_next = wd_cnt_reg + 31'h00000001;
      end
    end
    charge_next = !expired_next;
  end

  always_ff @(posedge clk) begin
    wd_cnt_reg  <= wd_cnt_next;
    expired_reg <= expired_next;
    charge_reg  <= charge_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Throttle alert

  // Overcurrent delay chosen by the host; low voltage delay is fixed
  always_comb begin
    case (tertiary_reg[`CCR_DEB_LSB +: 2])
      2'b00:   oc_delay = DEB_0;
      2'b01:   oc_delay = DEB_1;
      2'b10:   oc_delay = DEB_2;
      default: oc_delay = DEB_3;
    endcase
  end

  assign ac_over = sense.adapter_ma > ac_thr_reg;
  assign dc_over = sense.battery_ma > dc_thr_sel;

  ccr_debounce u_ac_deb (
    .clk    (clk),
    .resetn (resetn),
    .level  (ac_over),
    .delay  (oc_delay),
    .qual   (ac_qual)
  );

  ccr_debounce u_dc_deb (
    .clk    (clk),
    .resetn (resetn),
    .level  (dc_over),
    .delay  (oc_delay),
    .qual   (dc_qual)
  );

  ccr_debounce u_lsv_deb (
    .clk    (clk),
    .resetn (resetn),
    .level  (sense.low_sys_voltage),
    .delay  (LSV_DEB),
    .qual   (lsv_qual)
  );

  assign any_cause   = ac_qual || dc_qual || lsv_qual;
  // Code n holds for n+1 steps, so code 0 still gives a visible pulse
  assign hold_target = 17'(({14'h0000, tertiary_reg[`CCR_HOLD_LSB +: 3]}
                       + 17'h00001) * HOLD_STEP_CYC);

  // Latch on any cause, release only after hold time and no cause
  always_comb begin
    state_next    = state_reg;
    hold_cnt_next = hold_cnt_reg;
    alert_next    = alert_reg;
    if (!resetn) begin
      state_next    = ccr_pkg::CCR_IDLE;
      hold_cnt_next = 17'h00000;
      alert_next    = 1'b0;
    end else begin
      case (state_reg)
        ccr_pkg::CCR_IDLE: begin
          if (any_cause) begin
            state_next    = ccr_pkg::CCR_HOLD;
            hold_cnt_next = 17'h00001;
            alert_next    = 1'b1;
          end
        end
        ccr_pkg::CCR_HOLD: begin
          if (hold_cnt_reg < hold_target) begin
            hold_cnt_next = hold_cnt_reg + 17'h00001;
          end else if (!any_cause) begin
            state_next = ccr_pkg::CCR_IDLE;
            alert_next = 1'b0;
          end
        end
        default: begin
          state_next    = ccr_pkg::CCR_IDLE;
          hold_cnt_next = 17'h00000;
          alert_next    = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    state_reg    <= state_next;
    hold_cnt_reg <= hold_cnt_next;
    alert_reg    <= alert_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign rd_data     = rd_data_reg;
  assign cfg         = cfg_reg;
  assign charge_en   = charge_reg;
  assign wd_expired  = expired_reg;
  assign alert_n_out = 1'b0; // Open drain only ever pulls low
  assign alert_oe    = alert_reg;

endmodule

`default_nettype wire

// File: tb/ccr_host.sv
`default_nettype none

// Host side: one write-word transfer per call
module ccr_host (
  // Clock
  input  wire logic        clk,
  // Decoded transfer
  output ccr_pkg::ccr_wr_t wr
);
  timeunit 1ns;
  timeprecision 1ns;

  initial wr = '0;

  // Released fields show inverted garbage, never the old word
  task automatic put(input logic [7:0] c, input logic [15:0] d);
    @(posedge clk);
    #1 wr = '{valid: 1'b1, cmd: c, data: d};
    @(posedge clk);
    #1 wr = '{valid: 1'b0, cmd: ~c, data: ~d};
  endtask
endmodule

`default_nettype wire

// File: tb/ccr_regs_asserts.sv
`default_nettype none

// Port-level timing checks of the register bank
module ccr_regs_asserts #(
  parameter logic [30:0] WD_TIMEOUT_CYC = 31'h00000014,
  parameter logic [16:0] HOLD_STEP_CYC  = 17'h00004
) (
  // Clock and reset
  input wire logic                clk,
  input wire logic                resetn,
  // Transfers and read-back
  input wire ccr_pkg::ccr_wr_t    wr,
  input wire logic [7:0]          rd_cmd,
  input wire logic [15:0]         rd_data,
  // Power stage
  input wire ccr_pkg::ccr_sense_t sense,
  input wire ccr_pkg::ccr_cfg_t   cfg,
  input wire logic                charge_en,
  input wire logic                wd_expired,
  // Alert pin
  input wire logic                alert_n_in,
  input wire logic                alert_n_out,
  input wire logic                alert_oe
);
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [39:0] MV = {10'h320, 10'h258, 10'h1F4, 10'h190};

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Overcurrent causes and qualifying writes
  wire logic oc = sense.adapter_ma > cfg.ac_thr_ma ||
                  sense.battery_ma > cfg.dc_thr_ma;
  wire logic ceil_wr = wr.valid && (wr.cmd == 8'h10 || wr.cmd == 8'h11);
  wire logic pri_wr = wr.valid && wr.cmd == 8'h39;

  // Depths assume the short sim timeout and hold step
  a_wd_stop: assert property (wd_expired |-> !charge_en)
    else $error("charging while watchdog expired");
  a_wd_armed: assert property ($rose(wd_expired) |->
    $past(sense.adapter_present) && $past(sense.adapter_present, 16))
    else $error("watchdog expired without adapter");
  a_ceil_rearm: assert property (ceil_wr |=> !wd_expired && charge_en)
    else $error("ceiling write did not re-enable charge");
  a_hs_short: assert property (pri_wr ##1 !pri_wr |=>
    cfg.hs_short_mv == MV[10*$past(wr.data[6:5], 2) +: 10])
    else $error("short threshold mismatch");
  a_alert_cause: assert property ($rose(alert_oe) |->
    $past(oc || sense.low_sys_voltage, 2) &&
    $past(oc || sense.low_sys_voltage, 10))
    else $error("alert without debounced cause");
  a_lsv_fixed: assert property ($rose(alert_oe) && !$past(oc, 2) |->
    $past(sense.low_sys_voltage, 90))
    else $error("low voltage alert too early");
  a_alert_hold: assert property ($rose(alert_oe) |=> alert_oe[*3])
    else $error("alert released before hold");
  a_dc_lowpwr: assert property ($past(resetn) &&
    $past(sense.low_power_mode) && !$past(sense.power_monitor_en) |->
    cfg.dc_thr_ma inside {16'h2EE0, 16'h2710, 16'h1F40, 16'h1770})
    else $error("low power threshold not from table");

  // Main scenarios
  c_wd: cover property ($rose(wd_expired));
  c_alert: cover property ($rose(alert_oe));
  c_rearm: cover property (ceil_wr && wd_expired);
endmodule

////////////////////////////////////////////////////////////////////
bind ccr_regs ccr_regs_asserts #(
  .WD_TIMEOUT_CYC(WD_TIMEOUT_CYC), .HOLD_STEP_CYC(HOLD_STEP_CYC)
) u_chk (.clk, .resetn, .wr, .rd_cmd, .rd_data, .sense, .cfg, .charge_en,
  .wd_expired, .alert_n_in, .alert_n_out, .alert_oe);

`default_nettype wire

// File: tb/charger_control_regs_alert_timing_tb_top.sv
`default_nettype none

// Bench for the charger control register bank
module charger_control_regs_alert_timing_tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic                clk = 1'b0;
  logic                resetn = 1'b0;
  logic [7:0]          rd_cmd = 8'h00;
  ccr_pkg::ccr_sense_t sense = '0;
  ccr_pkg::ccr_wr_t    wr;
  logic [15:0]         rd_data;
  ccr_pkg::ccr_cfg_t   cfg;
  logic                charge_en;
  logic                wd_expired;
  logic                alert_n_out;
  logic                alert_oe;
  wire logic           alert_pin;
  int                  fails = 0;
  int                  samples_checked = 0;
  int                  cyc = 0;
  logic [9:0]          mv [4] = '{10'h190, 10'h1F4, 10'h258, 10'h320};
  logic [15:0]         lp [4] = '{16'h2EE0, 16'h2710, 16'h1F40, 16'h1770};
  int                  deb [4] = '{10, 50, 100, 400};
  logic [7:0]          rc [6] = '{8'h39, 8'h3C, 8'h3D, 8'h47, 8'h48, 8'h50};
  logic [15:0]         rv [6] = '{16'h0, 16'h0, 16'h0, 16'h0C00, 16'h1000,
                                  16'h0};

  // Pulled-up open-drain line
  assign alert_pin = alert_oe ? alert_n_out : 1'b1;

  // Clock
  always #50 clk = ~clk;

  ccr_host host (.clk, .wr);

  ccr_regs #(.WD_TIMEOUT_CYC(31'h00000014), .HOLD_STEP_CYC(17'h00004)) DUT (
    .clk, .resetn, .wr, .rd_cmd, .rd_data, .sense, .cfg, .charge_en,
    .wd_expired, .alert_n_in(alert_pin), .alert_n_out, .alert_oe);

  ////////////////////////////////////////////////////////////////////
  // Inputs always move 1 ns after an edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // Read-back is registered, so allow two edges
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    rd_cmd = c;
    step(2);
    chk(rd_data, e);
  endtask

  // Bounded wait for the alert level
  task automatic wait_lvl(input logic v, output int n);
    n = 0;
    while (alert_oe !== v && n < 600) begin
      step(1);
      n++;
    end
  endtask

  task automatic results();
    if (fails == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////
  initial begin
    int n;
    int m;
    step(3);
    resetn = 1'b1;
    chk(16'({charge_en, wd_expired, alert_oe}), 16'h4);
    chk(16'(cfg.hs_short_mv), 16'h190);
    foreach (rc[i]) rd(rc[i], rv[i]);
    // Short-detect codes; upper byte of the primary word is dropped
    for (int i = 0; i < 4; i++) begin
      host.put(8'h39, 16'hFF00 | 16'(i << 5));
      step(1);
      chk(16'(cfg.hs_short_mv), 16'(mv[i]));
      rd(8'h39, 16'(i << 5));
    end
    host.put(8'h3C, 16'hA5C3);
    rd(8'h3C, 16'hA5C3);
    chk(cfg.secondary_word, 16'hA5C3);
    // Discharge threshold source selection
    sense.low_power_mode = 1'b1;
    for (int i = 0; i < 4; i++) begin
      host.put(8'h39, 16'(i << 3));
      step(1);
      chk(cfg.dc_thr_ma, lp[i]);
    end
    sense.power_monitor_en = 1'b1;
    host.put(8'h48, 16'hFFFF);
    step(1);
    chk(cfg.dc_thr_ma, 16'h3F00);
    sense = '0;
    host.put(8'h48, 16'h1000);
    // Adapter threshold is masked; kept below the test current
    host.put(8'h47, 16'h2F80);
    rd(8'h47, 16'h0F80);
    chk(cfg.ac_thr_ma, 16'h0F80);
    // Watchdog: restart, expiry, latch, re-enable, disable
    sense.adapter_present = 1'b1;
    step(15);
    host.put(8'h10, 16'h0000);
    step(15);
    chk(16'(wd_expired), 16'h0);
    step(10);
    chk(16'({wd_expired, charge_en}), 16'h2);
    sense.adapter_present = 1'b0;
    step(3);
    chk(16'(wd_expired), 16'h1);
    host.put(8'h11, 16'h0000);
    step(1);
    chk(16'({wd_expired, charge_en}), 16'h1);
    host.put(8'h39, 16'h0080);
    sense.adapter_present = 1'b1;
    step(40);
    chk(16'(wd_expired), 16'h0);
    sense.adapter_present = 1'b0;
    // Pulse shorter than the debounce is ignored
    sense.adapter_ma = 16'h1000;
    step(5);
    sense.adapter_ma = 16'h0000;
    step(20);
    chk(16'(alert_oe), 16'h0);
    // Each debounce code with a growing hold code
    for (int i = 0; i < 4; i++) begin
      host.put(8'h3D, 16'((i << 9) | (i << 6)));
      rd(8'h3D, 16'((i << 9) | (i << 6)));
      // Odd codes use the battery cause, even ones the adapter cause
      if (i % 2 == 1) begin
        sense.battery_ma = 16'h2000;
      end else begin
        sense.adapter_ma = 16'h1000;
      end
      wait_lvl(1'b1, n);
      chk(16'(alert_pin), 16'h0);
      {sense.adapter_ma, sense.battery_ma} = 32'h00000000;
      wait_lvl(1'b0, m);
      chk(16'(alert_pin), 16'h1);
      chk(16'(n >= deb[i] && n <= deb[i] + 3), 16'h1);
      chk(16'(m >= 4 * i + 3 && m <= 4 * i + 7), 16'h1);
    end
    // Low system voltage keeps its own fixed debounce
    sense.low_sys_voltage = 1'b1;
    wait_lvl(1'b1, n);
    sense.low_sys_voltage = 1'b0;
    chk(16'(n >= 99 && n <= 103), 16'h1);
    wait_lvl(1'b0, m);
    chk(16'(m >= 15 && m <= 19), 16'h1);
    results();
  end
endmodule

`default_nettype wire
